// File: rlis_top.sv
// axi4-lite slave for lock status and identification registers
// assumes dbg_access_in is a same-clock qualifier for the current access
`timescale 1ns/10ps
`default_nettype none
module rlis_top
(
    input  wire logic        clk_in,         // 250 mhz core clock
    input  wire logic        srst_in,        // sync reset, high
    input  wire logic        ce_in,          // freezes all state when low
    input  wire logic        dbg_access_in,  // access comes from external debugger
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             locked_out      // lock engaged, for system use
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // word-aligned address match, ignoring byte offset bits
    function automatic logic rlis_hit(input logic [11:0] a, input logic [11:0] off);
        rlis_hit = (a[11:2] == off[11:2]);
    endfunction : rlis_hit

    // a register offset is mapped if any of the known words match
    function automatic logic rlis_mapped(input logic [11:0] a);
        rlis_mapped = rlis_hit(a, rlis_pkg::RLIS_OFF_CLAIM_SET)
                    | rlis_hit(a, rlis_pkg::RLIS_OFF_CLAIM_CLR)
                    | rlis_hit(a, rlis_pkg::RLIS_OFF_LOCK_KEY)
                    | rlis_hit(a, rlis_pkg::RLIS_OFF_LOCK_STATE)
                    | rlis_hit(a, rlis_pkg::RLIS_OFF_AUTH)
                    | rlis_hit(a, rlis_pkg::RLIS_OFF_CAPS)
                    | rlis_hit(a, rlis_pkg::RLIS_OFF_CLASS);
    endfunction : rlis_mapped

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [11:0] aw_addr_r;    // captured write address
    logic        aw_have_r;    // write address held
    logic [31:0] w_data_r;     // captured write data
    logic [3:0]  w_strb_r;     // captured write strobes
    logic        w_have_r;     // write data held
    logic        wr_fire;      // both halves present, no response pending
    logic        wr_dbg;       // write comes from external debugger
    logic        wr_key;       // write targets key register
    logic        wr_allowed;   // write passes the lock
    logic        key_wr;       // key update strobe
    logic [3:0]  claim_r;      // small claim tag, a writable register
    logic [31:0] rd_word;      // read mux output
    logic        lock_now;     // lock module state
    logic        unused_ok;    // prot bits carry no meaning here

    assign unused_ok = ^{s_axi_awprot, s_axi_arprot};

    // ------------------------------------------------------------
    // write channel capture; order of aw and w is free
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            aw_have_r     <= 1'b0;
            aw_addr_r     <= 12'h000;
            s_axi_awready <= 1'b0;
        end
        else if (ce_in)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            else if (wr_fire)
            begin
                aw_have_r     <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            else
                // ready only while nothing is held
                s_axi_awready <= !aw_have_r;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            w_have_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else if (ce_in)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            else if (wr_fire)
            begin
                w_have_r     <= 1'b0;
                s_axi_wready <= 1'b1;
            end
            else
                s_axi_wready <= !w_have_r;
        end
    end

    // ------------------------------------------------------------
    // write decision
    // ------------------------------------------------------------
    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    // sampled at the write's execution; debugger flag must be held with the transfer
    assign wr_dbg  = dbg_access_in;
    assign wr_key  = rlis_hit(aw_addr_r, rlis_pkg::RLIS_OFF_LOCK_KEY);
    assign wr_allowed = wr_dbg || !lock_now || wr_key;
    // key writes from debugger have no lock, ignored
    assign key_wr  = wr_fire && wr_key && !wr_dbg && (w_strb_r == 4'hf);

    rlis_lock u_lock
    (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .ce_in       (ce_in),
        .key_wr_in   (key_wr),
        .key_data_in (w_data_r),
        .locked_out  (lock_now)
    );

    // claim tag gives software one writable register to test the lock on
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            claim_r <= rlis_pkg::RLIS_CLAIM_RESET;
        else if (ce_in && wr_fire && wr_allowed && w_strb_r[0])
        begin
            if (rlis_hit(aw_addr_r, rlis_pkg::RLIS_OFF_CLAIM_SET))
                claim_r <= claim_r | w_data_r[3:0];
            else if (rlis_hit(aw_addr_r, rlis_pkg::RLIS_OFF_CLAIM_CLR))
                claim_r <= claim_r & ~w_data_r[3:0];
        end
    end

    // ------------------------------------------------------------
    // write response; refused writes still answer okay, unmapped slverr
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rlis_pkg::RLIS_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                // writes to read-only words do nothing
                s_axi_bresp  <= rlis_mapped(aw_addr_r) ? rlis_pkg::RLIS_RESP_OKAY
                                                       : rlis_pkg::RLIS_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_LOCK_STATE))
        begin
            if (!dbg_access_in)
            begin
                rd_word[rlis_pkg::RLIS_RPT_PRESENT_BIT] = 1'b1;
                rd_word[rlis_pkg::RLIS_RPT_ENGAGED_BIT] = lock_now;
                rd_word[rlis_pkg::RLIS_RPT_WIDTH_BIT]   = 1'b0;
            end
        end
        else if (rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_AUTH))
            rd_word[7:0] = rlis_pkg::RLIS_AUTH_LEVELS;
        else if (rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_CAPS))
            rd_word[3:0] = rlis_pkg::RLIS_PORT_COUNT;
        else if (rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_CLASS))
            rd_word[7:0] = {rlis_pkg::RLIS_CLASS_SUB, rlis_pkg::RLIS_CLASS_MAJOR};
        else if (rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_CLAIM_SET))
            rd_word[3:0] = 4'hf;
        else if (rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_CLAIM_CLR))
            rd_word[3:0] = claim_r;
    end

    // ------------------------------------------------------------
    // read channel; one beat answered the edge after the address
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= rlis_pkg::RLIS_RESP_OKAY;
        end
        else if (ce_in)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rlis_mapped(s_axi_araddr) ? rlis_pkg::RLIS_RESP_OKAY
                                                           : rlis_pkg::RLIS_RESP_SLVERR;
            end
            else if (s_axi_rvalid)
            begin
                if (s_axi_rready)
                    s_axi_rvalid <= 1'b0;
            end
            else
                s_axi_arready <= 1'b1;
        end
    end

    // mirror of lock state as a registered output
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            locked_out <= rlis_pkg::RLIS_LOCK_RESET;
        else if (ce_in)
            locked_out <= lock_now;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a plain on-chip read of the lock report word
    sequence s_rpt_read;
        ce_in && s_axi_arvalid && s_axi_arready && !dbg_access_in
            && rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_LOCK_STATE);
    endsequence

    a_rpt_present: assert property (@(posedge clk_in) disable iff (srst_in)
        s_rpt_read |=> s_axi_rvalid && s_axi_rdata[0] && !s_axi_rdata[2])
        else $error("lock status read lacks present bit");
    a_rpt_engaged: assert property (@(posedge clk_in) disable iff (srst_in)
        s_rpt_read |=> s_axi_rdata[1] == $past(lock_now))
        else $error("lock engaged bit wrong");
    a_rpt_dbg_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && s_axi_arvalid && s_axi_arready && dbg_access_in
            && rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_LOCK_STATE)
            |=> s_axi_rdata == 32'h0000_0000)
        else $error("debugger lock status not zero");
    a_ident_values: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && s_axi_arvalid && s_axi_arready
            && rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_CLASS)
            |=> s_axi_rdata == 32'h0000_0022)
        else $error("component class wrong");
    a_auth_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && s_axi_arvalid && s_axi_arready
            && rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_AUTH)
            |=> s_axi_rdata == 32'h0000_0000)
        else $error("debug levels not zero");
    a_caps_ports: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && s_axi_arvalid && s_axi_arready
            && rlis_hit(s_axi_araddr, rlis_pkg::RLIS_OFF_CAPS)
            |=> s_axi_rdata == 32'h0000_0002)
        else $error("port count wrong");
    a_locked_claim: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && wr_fire && lock_now && !wr_dbg |=> $stable(claim_r))
        else $error("locked write changed state");
    a_refused_okay: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && wr_fire && !wr_allowed && rlis_mapped(aw_addr_r)
            |=> s_axi_bvalid && s_axi_bresp == rlis_pkg::RLIS_RESP_OKAY)
        else $error("refused write not answered okay");
    a_dbg_key_ign: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && wr_fire && wr_dbg && wr_key |=> $stable(lock_now))
        else $error("debugger key write changed lock");
    a_key_path: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && wr_fire && wr_key && !wr_dbg && (w_strb_r == 4'hf)
            |=> lock_now == ($past(w_data_r) != rlis_pkg::RLIS_UNLOCK_KEY))
        else $error("on-chip key write lost");
    a_unmapped_zero: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && s_axi_arvalid && s_axi_arready && !rlis_mapped(s_axi_araddr)
            |=> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == rlis_pkg::RLIS_RESP_SLVERR)
        else $error("unmapped read not zero");
    a_read_locked: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_lock_mirror: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in |=> locked_out == $past(lock_now))
        else $error("lock output does not follow lock");
endmodule : rlis_top
`default_nettype wire

// File: rlis_pkg.sv
// constants for the replicator lock and identification status bank
// assumes a 32-bit axi4-lite slave port on a single 250 mhz clock
//
// What this block does
// - key width flag always reads zero
// - lock engaged flag shows lock state
// - locked interface still reads, writes refused
// - no lock present: key writes ignored
// - lock present flag reads one if lock
// - secure debug level fields read zero
// - nonsecure debug level fields read zero
// - output port count reads two
// - sub class reads replicator code
// - major class reads trace in/out code
// - magic key unlocks, other values lock
// - locked: on-chip writes refused except key
// - status reads zero from external debugger
package rlis_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] RLIS_OFF_CLAIM_SET  = 12'hfa0;  // scratch claim set
    localparam logic [11:0] RLIS_OFF_CLAIM_CLR  = 12'hfa4;  // scratch claim clear
    localparam logic [11:0] RLIS_OFF_LOCK_KEY   = 12'hfb0;  // lock_key_register
    localparam logic [11:0] RLIS_OFF_LOCK_STATE = 12'hfb4;  // lock_state_report
    localparam logic [11:0] RLIS_OFF_AUTH       = 12'hfb8;  // debug_auth_levels
    localparam logic [11:0] RLIS_OFF_CAPS       = 12'hfc8;  // capability_info
    localparam logic [11:0] RLIS_OFF_CLASS      = 12'hfcc;  // component_class
    // ------------------------------------------------------------
    // field positions and fixed values
    // ------------------------------------------------------------
    localparam int          RLIS_RPT_PRESENT_BIT = 0;
    localparam int          RLIS_RPT_ENGAGED_BIT = 1;
    localparam int          RLIS_RPT_WIDTH_BIT   = 2;
    localparam logic [31:0] RLIS_UNLOCK_KEY      = 32'hc5acce55;
    localparam logic [7:0]  RLIS_AUTH_LEVELS     = 8'h00;   // all four fields 0b00
    localparam logic [3:0]  RLIS_PORT_COUNT      = 4'h2;
    localparam logic [3:0]  RLIS_CLASS_SUB       = 4'h2;
    localparam logic [3:0]  RLIS_CLASS_MAJOR     = 4'h2;
    localparam logic        RLIS_LOCK_RESET      = 1'b1;    // locked out of reset
    localparam logic [3:0]  RLIS_CLAIM_RESET     = 4'h0;
    localparam logic [1:0]  RLIS_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RLIS_RESP_SLVERR     = 2'h2;
endpackage : rlis_pkg

// File: rlis_lock.sv
// software lock state holder
// assumes write strobes come from the bus slave on the same clock
`timescale 1ns/10ps
`default_nettype none
module rlis_lock
(
    input  wire logic        clk_in,      // core clock
    input  wire logic        srst_in,     // sync reset, high
    input  wire logic        ce_in,       // clock enable
    input  wire logic        key_wr_in,   // on-chip write to key register
    input  wire logic [31:0] key_data_in, // written key value
    output logic             locked_out   // lock engaged
);
    // ------------------------------------------------------------
    // lock flip-flop
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            locked_out <= rlis_pkg::RLIS_LOCK_RESET;
        else if (ce_in && key_wr_in)
            locked_out <= (key_data_in != rlis_pkg::RLIS_UNLOCK_KEY);
    end

    a_key_unlocks: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && key_wr_in |=> locked_out == (($past(key_data_in)) != rlis_pkg::RLIS_UNLOCK_KEY))
        else $error("lock state does not follow key write");
endmodule : rlis_lock
`default_nettype wire

// File: rlis_top_tb.sv
// self-checking bench for the lock status and identification bank
// assumes rlis_top alone, driven over axi4-lite on one 250 mhz clock
`timescale 1ns/10ps
`default_nettype none
module rlis_top_tb;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk_in;     // core clock
    logic        srst_in;    // sync reset, high
    logic        dbg;        // access comes from external debugger
    logic        aw_valid;   // write address channel
    logic        aw_ready;
    logic [11:0] aw_addr;
    logic        w_valid;    // write data channel
    logic        w_ready;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [3:0]  wr_strb;    // strobes the write task offers
    logic        b_valid;    // write response channel
    logic        b_ready;
    logic [1:0]  b_resp;
    logic        ar_valid;   // read address channel
    logic        ar_ready;
    logic [11:0] ar_addr;
    logic        r_valid;    // read data channel
    logic        r_ready;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic        locked;     // lock engaged, from design
    int          err_total;  // mismatches
    int          checked;    // comparisons made
    logic [11:0] ro_addr [3];
    logic [31:0] ro_exp  [3];

    // ------------------------------------------------------------
    // design under test, clock enable tied high
    // ------------------------------------------------------------
    rlis_top u_rlis_top (
        .clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .dbg_access_in(dbg),
        .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_awaddr(aw_addr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
        .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_bvalid(b_valid),
        .s_axi_bready(b_ready), .s_axi_bresp(b_resp), .s_axi_arvalid(ar_valid),
        .s_axi_arready(ar_ready), .s_axi_araddr(ar_addr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .s_axi_rdata(r_data),
        .s_axi_rresp(r_resp), .locked_out(locked));

    // half period of 2 ns
    always #2 clk_in = ~clk_in;

    // ------------------------------------------------------------
    // report and compare tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_resp

    // a wait that ran dry counts as a mismatch and ends the run
    task automatic timed_out(input string what);
        err_total++;
        $display("BAD timeout on %s", what);
        complete_run();
    endtask : timed_out

    // ------------------------------------------------------------
    // bus tasks: ready is looked at mid-cycle, where it is settled,
    // and the channel is released by nba after the taking edge
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic q, input logic [31:0] d,
                      input logic [1:0] er);
        int   n;
        logic aw_p, w_p, aw_hit, w_hit, b_hit, done;
        @(posedge clk_in);
        dbg      <= q;
        aw_valid <= 1'b1;
        aw_addr  <= a;
        w_valid  <= 1'b1;
        w_data   <= d;
        w_strb   <= wr_strb;
        b_ready  <= 1'b1;
        aw_p = 1'b1;
        w_p  = 1'b1;
        done = 1'b0;
        n    = 0;
        while (!done && n < 200)
        begin
            @(negedge clk_in);
            n++;
            aw_hit = aw_p && aw_ready;
            w_hit  = w_p && w_ready;
            b_hit  = b_valid;
            if (b_hit)
                chk_resp("bresp", er, b_resp);
            @(posedge clk_in);
            if (aw_hit)
            begin
                aw_valid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_hit)
            begin
                w_valid <= 1'b0;
                w_p = 1'b0;
            end
            if (b_hit)
            begin
                b_ready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done)
            timed_out("write");
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic q, input logic [31:0] e,
                      input logic [1:0] er);
        int   n;
        logic ar_p, ar_hit, r_hit, done;
        @(posedge clk_in);
        dbg      <= q;
        ar_valid <= 1'b1;
        ar_addr  <= a;
        r_ready  <= 1'b1;
        ar_p = 1'b1;
        done = 1'b0;
        n    = 0;
        while (!done && n < 200)
        begin
            @(negedge clk_in);
            n++;
            ar_hit = ar_p && ar_ready;
            r_hit  = !ar_p && r_valid;
            if (r_hit)
            begin
                chk_word("rdata", e, r_data);
                chk_resp("rresp", er, r_resp);
            end
            @(posedge clk_in);
            if (ar_hit)
            begin
                ar_valid <= 1'b0;
                ar_p = 1'b0;
            end
            if (r_hit)
            begin
                r_ready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done)
            timed_out("read");
    endtask : rd

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        srst_in = 1'b1;
        dbg = 1'b0;
        aw_valid = 1'b0;
        aw_addr = 12'h000;
        w_valid = 1'b0;
        w_data = 32'h0;
        w_strb = 4'h0;
        wr_strb = 4'hf;
        b_ready = 1'b0;
        ar_valid = 1'b0;
        ar_addr = 12'h000;
        r_ready = 1'b0;
        err_total = 0;
        checked = 0;
        // fixed identification words and their expected values
        ro_addr = '{rlis_pkg::RLIS_OFF_AUTH, rlis_pkg::RLIS_OFF_CAPS, rlis_pkg::RLIS_OFF_CLASS};
        ro_exp  = '{32'h00000000, 32'h00000002, 32'h00000022};
        repeat (10) @(posedge clk_in);
        srst_in <= 1'b0;
        // locked out of reset, lock present, 32-bit key
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b0, 32'h3, 2'h0);
        chk_word("locked_out", 32'h1, {31'h0, locked});
        // debugger sees the lock status as zero
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b1, 32'h0, 2'h0);
        // id words read fixed, ignore writes of all ones
        for (int i = 0; i < 3; i++)
        begin
            rd(ro_addr[i], 1'b0, ro_exp[i], 2'h0);
            wr(ro_addr[i], 1'b1, 32'hffffffff, 2'h0);
            rd(ro_addr[i], 1'b0, ro_exp[i], 2'h0);
        end
        // locked: on-chip write refused yet reads still served
        wr(rlis_pkg::RLIS_OFF_CLAIM_SET, 1'b0, 32'h5, 2'h0);
        rd(rlis_pkg::RLIS_OFF_CLAIM_CLR, 1'b0, 32'h0, 2'h0);
        // debugger writes pass the lock
        wr(rlis_pkg::RLIS_OFF_CLAIM_SET, 1'b1, 32'h3, 2'h0);
        rd(rlis_pkg::RLIS_OFF_CLAIM_CLR, 1'b1, 32'h3, 2'h0);
        wr(rlis_pkg::RLIS_OFF_CLAIM_CLR, 1'b1, 32'hf, 2'h0);
        // debugger has no lock: its key write changes nothing
        wr(rlis_pkg::RLIS_OFF_LOCK_KEY, 1'b1, 32'hc5acce55, 2'h0);
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b0, 32'h3, 2'h0);
        // a key one bit off keeps the lock
        wr(rlis_pkg::RLIS_OFF_LOCK_KEY, 1'b0, 32'hc5acce54, 2'h0);
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b0, 32'h3, 2'h0);
        // the right key releases it
        wr(rlis_pkg::RLIS_OFF_LOCK_KEY, 1'b0, 32'hc5acce55, 2'h0);
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b0, 32'h1, 2'h0);
        chk_word("locked_out", 32'h0, {31'h0, locked});
        wr(rlis_pkg::RLIS_OFF_CLAIM_SET, 1'b0, 32'h5, 2'h0);
        rd(rlis_pkg::RLIS_OFF_CLAIM_CLR, 1'b0, 32'h5, 2'h0);
        // a partial-word key write is no key write
        wr_strb = 4'h1;
        wr(rlis_pkg::RLIS_OFF_LOCK_KEY, 1'b0, 32'h0, 2'h0);
        wr_strb = 4'hf;
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b0, 32'h1, 2'h0);
        // unmapped word: error response, zero data
        rd(12'h000, 1'b0, 32'h0, rlis_pkg::RLIS_RESP_SLVERR);
        wr(12'h004, 1'b0, 32'h1, rlis_pkg::RLIS_RESP_SLVERR);
        // any other key value engages the lock again
        wr(rlis_pkg::RLIS_OFF_LOCK_KEY, 1'b0, 32'h0, 2'h0);
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b0, 32'h3, 2'h0);
        // unlock, then a mid-run reset locks once more
        wr(rlis_pkg::RLIS_OFF_LOCK_KEY, 1'b0, 32'hc5acce55, 2'h0);
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(rlis_pkg::RLIS_OFF_LOCK_STATE, 1'b0, 32'h3, 2'h0);
        complete_run();
    end
endmodule : rlis_top_tb
`default_nettype wire
